// >>> common/timer_event_pkg.sv
/*
  Shared constants and carriers for the three-channel event timer:
  register offsets, control and status layouts, reset values.
  Assumes a single core clock and a plain strobed register port.
*/
package timer_event_pkg;

  localparam int NUM_CH = 3;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 6;
  localparam int OFS_W  = 4;
  localparam int CH_W   = 2;
  localparam int NUM_SRC = 9;
  localparam int SRC_W  = 4;

  // Word index inside a channel window; channel sits in i_addr[5:4]
  localparam logic [OFS_W-1:0] OFS_CTRL   = 4'h0;
  localparam logic [OFS_W-1:0] OFS_COUNT  = 4'h1;
  localparam logic [OFS_W-1:0] OFS_REG_A  = 4'h2;
  localparam logic [OFS_W-1:0] OFS_REG_B  = 4'h3;
  localparam logic [OFS_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [OFS_W-1:0] OFS_REG_C  = 4'h5;
  localparam logic [OFS_W-1:0] OFS_REG_D  = 4'h6;

  localparam logic [DATA_W-1:0] CTRL_RESET  = 16'h0000;
  localparam logic [DATA_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] REG_RESET   = 16'hffff;
  localparam logic [DATA_W-1:0] COUNT_MAX   = 16'hffff;
  localparam logic [DATA_W-1:0] COUNT_STEP  = 16'h0001;
  localparam logic [DATA_W-1:0] READ_ZERO   = 16'h0000;

  localparam logic [1:0] OUT_KEEP   = 2'h0;
  localparam logic [1:0] OUT_LOW    = 2'h1;
  localparam logic [1:0] OUT_HIGH   = 2'h2;
  localparam logic [1:0] OUT_TOGGLE = 2'h3;

  // Control word, bit 15 down to bit 0
  typedef struct packed {
    logic       slow_clk;
    logic       alt_src;
    logic       mode_ext;
    logic       trig_en;
    logic       ie_ovf;
    logic       ie_b;
    logic       ie_a;
    logic [1:0] b_out;
    logic [1:0] a_out;
    logic       b_cap;
    logic       a_cap;
    logic       clr_b;
    logic       clr_a;
    logic       run;
  } ctrl_t;

  // Status word, bit 2 down to bit 0
  typedef struct packed {
    logic ovf;
    logic b;
    logic a;
  } flags_t;

  localparam flags_t FLAGS_RESET = 3'h0;

endpackage : timer_event_pkg

// >>> verilog/timer_event_unit.sv
/*
  Three-channel 16-bit event timer: counters, compare and capture
  registers, status flags with read-then-write-zero clearing, interrupt
  requests, converter start pulses and the write/event contention rules.
  Assumes a strobed register port on i_core_clk (one-cycle strobes,
  read data the cycle after) and asynchronous capture pins.
*/
`timescale 1ns/1ps
module timer_event_unit
  import timer_event_pkg::*;
#(
  parameter int PRESCALE_DIV = 4
)(
  input  wire logic                                 i_core_clk,
  input  wire logic                                 i_rst_b,
  input  wire logic [timer_event_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [timer_event_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic                                 i_wr,
  input  wire logic                                 i_rd,
  output logic      [timer_event_pkg::DATA_W-1:0]  o_rdata,
  input  wire logic [timer_event_pkg::NUM_CH-1:0]  i_pin_a_in,
  input  wire logic [timer_event_pkg::NUM_CH-1:0]  i_pin_b_in,
  output logic      [timer_event_pkg::NUM_CH-1:0]  o_pin_a_out,
  output logic      [timer_event_pkg::NUM_CH-1:0]  o_pin_a_oe,
  output logic      [timer_event_pkg::NUM_CH-1:0]  o_pin_b_out,
  output logic      [timer_event_pkg::NUM_CH-1:0]  o_pin_b_oe,
  output logic      [timer_event_pkg::NUM_CH-1:0]  o_match_irq_a,
  output logic      [timer_event_pkg::NUM_CH-1:0]  o_match_irq_b,
  output logic      [timer_event_pkg::NUM_CH-1:0]  o_overflow_irq,
  output logic                                      o_irq_top_valid,
  output logic      [timer_event_pkg::SRC_W-1:0]   o_irq_top_src,
  output logic      [timer_event_pkg::NUM_CH-1:0]  o_adc_start
);
  import timer_event_pkg::*;

  localparam int DIV_W = (PRESCALE_DIV > 1) ? $clog2(PRESCALE_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PRESCALE_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;
  localparam logic [DIV_W-1:0] DIV_ONE  = DIV_W'(1);

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input int ch,
                               input logic [OFS_W-1:0] ofs);
    hit = (a[ADDR_W-1 -: CH_W] == CH_W'(ch)) && (a[OFS_W-1:0] == ofs);
  endfunction : hit

  // State
  ctrl_t               ctrl_q  [NUM_CH];
  ctrl_t               ctrl_d  [NUM_CH];
  logic [DATA_W-1:0]   count_q [NUM_CH];
  logic [DATA_W-1:0]   count_d [NUM_CH];
  logic [DATA_W-1:0]   a_q     [NUM_CH];
  logic [DATA_W-1:0]   a_d     [NUM_CH];
  logic [DATA_W-1:0]   b_q     [NUM_CH];
  logic [DATA_W-1:0]   b_d     [NUM_CH];
  flags_t              flags_q [NUM_CH];
  flags_t              flags_d [NUM_CH];
  flags_t              armed_q [NUM_CH];
  flags_t              armed_d [NUM_CH];
  logic [DATA_W-1:0]   c_q;
  logic [DATA_W-1:0]   c_d;
  logic [DATA_W-1:0]   d_q;
  logic [DATA_W-1:0]   d_d;
  logic [DIV_W-1:0]    div_q;
  logic [DIV_W-1:0]    div_d;
  logic [DATA_W-1:0]   rdata_d;
  logic [NUM_CH-1:0]   pa_out_d;
  logic [NUM_CH-1:0]   pa_oe_d;
  logic [NUM_CH-1:0]   pb_out_d;
  logic [NUM_CH-1:0]   pb_oe_d;
  logic [NUM_CH-1:0]   irq_a_d;
  logic [NUM_CH-1:0]   irq_b_d;
  logic [NUM_CH-1:0]   irq_ovf_d;
  logic                top_valid_d;
  logic [SRC_W-1:0]    top_src_d;
  logic [NUM_CH-1:0]   adc_d;

  // Pin synchronisers; stage 1 feeds stage 2 only
  logic [NUM_CH-1:0]   pa_s1;
  logic [NUM_CH-1:0]   pa_s2;
  logic [NUM_CH-1:0]   pa_s3;
  logic [NUM_CH-1:0]   pb_s1;
  logic [NUM_CH-1:0]   pb_s2;
  logic [NUM_CH-1:0]   pb_s3;

  // Event terms
  logic [NUM_CH-1:0]   tick;
  logic [NUM_CH-1:0]   inc;
  logic [NUM_CH-1:0]   ma;
  logic [NUM_CH-1:0]   mb;
  logic [NUM_CH-1:0]   cap_a;
  logic [NUM_CH-1:0]   cap_b;
  logic [NUM_CH-1:0]   evt_a;
  logic [NUM_CH-1:0]   evt_b;
  logic [NUM_CH-1:0]   clr;
  logic [NUM_CH-1:0]   ovf;
  logic [NUM_CH-1:0]   wr_cnt;
  logic                div_tick;
  logic                lower_ovf;
  logic                casc_cnt;
  logic                c_evt;
  logic [DATA_W-1:0]   c_new;
  logic [DATA_W-1:0]   d_new;
  logic [NUM_SRC-1:0]  pend;

  always_comb
  begin
    div_tick = (div_q == DIV_ZERO);
    div_d    = div_tick ? DIV_LAST : div_q - DIV_ONE;

    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      tick[ch]   = ctrl_q[ch].run &&
                   (!ctrl_q[ch].slow_clk || div_tick);
      wr_cnt[ch] = i_wr && hit(i_addr, ch, OFS_COUNT);
    end

    // Channel 1 counts on channel 2 overflow in cascade mode
    lower_ovf = tick[2] && (count_q[2] == COUNT_MAX);
    if (ctrl_q[1].mode_ext)
      tick[1] = ctrl_q[1].run && lower_ovf;
    casc_cnt = tick[1] && !wr_cnt[2];

    // Match only in the last equal state, just before the count clock
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      ma[ch] = tick[ch] && (count_q[ch] == a_q[ch]) &&
               !ctrl_q[ch].a_cap;
      mb[ch] = tick[ch] && (count_q[ch] == b_q[ch]) &&
               !ctrl_q[ch].b_cap;
      cap_a[ch] = ctrl_q[ch].a_cap && pa_s2[ch] && !pa_s3[ch];
      cap_b[ch] = ctrl_q[ch].b_cap && pb_s2[ch] && !pb_s3[ch];
    end

    // Channel 0 C event: cascade count when alt_src (C then loads count 0 every cycle), else compare
    if (ctrl_q[0].alt_src)
    begin
      cap_a[0] = casc_cnt;
      c_evt    = casc_cnt;
    end
    else
      c_evt = tick[0] && (count_q[0] == c_q) && !ctrl_q[0].mode_ext;
    if (ctrl_q[1].alt_src)
      cap_b[1] = c_evt;

    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      evt_a[ch] = ma[ch] || cap_a[ch];
      evt_b[ch] = mb[ch] || cap_b[ch];
      clr[ch]   = (ctrl_q[ch].clr_a && evt_a[ch]) ||
                  (ctrl_q[ch].clr_b && evt_b[ch]);
      inc[ch]   = tick[ch];
    end
    if (ctrl_q[1].mode_ext)
      inc[1] = casc_cnt;

    c_new = (i_wr && hit(i_addr, 0, OFS_REG_C)) ? i_wdata : c_q;
    d_new = (i_wr && hit(i_addr, 0, OFS_REG_D)) ? i_wdata : d_q;
    c_d   = c_new;
    d_d   = d_new;

    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      ctrl_d[ch] = ctrl_q[ch];
      if (i_wr && hit(i_addr, ch, OFS_CTRL))
        ctrl_d[ch] = ctrl_t'(i_wdata);

      // Clear beats write, write beats increment
      ovf[ch] = inc[ch] && (count_q[ch] == COUNT_MAX) &&
                !clr[ch] && !wr_cnt[ch];
      if (clr[ch])
        count_d[ch] = COUNT_RESET;
      else if (wr_cnt[ch])
        count_d[ch] = i_wdata;
      else if (inc[ch])
        count_d[ch] = count_q[ch] + COUNT_STEP;
      else
        count_d[ch] = count_q[ch];

      // General register A
      a_d[ch] = a_q[ch];
      if (cap_a[ch])
        a_d[ch] = count_q[ch];
      else if (ch == 0 && ctrl_q[0].mode_ext && ma[ch])
        a_d[ch] = c_new;
      else if (i_wr && hit(i_addr, ch, OFS_REG_A))
        a_d[ch] = i_wdata;

      // General register B
      b_d[ch] = b_q[ch];
      if (cap_b[ch])
        b_d[ch] = count_q[ch];
      else if (ch == 0 && ctrl_q[0].mode_ext && mb[ch])
        b_d[ch] = d_new;
      else if (i_wr && hit(i_addr, ch, OFS_REG_B))
        b_d[ch] = i_wdata;

      // Status flags: set wins over clear
      armed_d[ch] = armed_q[ch];
      flags_d[ch] = flags_q[ch];
      if (i_rd && hit(i_addr, ch, OFS_STATUS))
        armed_d[ch] = armed_q[ch] | flags_q[ch];
      if (i_wr && hit(i_addr, ch, OFS_STATUS))
      begin
        flags_d[ch] = flags_q[ch] &
                      ~(armed_q[ch] & ~flags_t'(i_wdata));
        armed_d[ch] = FLAGS_RESET;
      end
      if (evt_a[ch])
        flags_d[ch].a = 1'b1;
      if (evt_b[ch])
        flags_d[ch].b = 1'b1;
      if (ovf[ch])
        flags_d[ch].ovf = 1'b1;

      irq_a_d[ch]   = flags_d[ch].a && ctrl_d[ch].ie_a;
      irq_b_d[ch]   = flags_d[ch].b && ctrl_d[ch].ie_b;
      irq_ovf_d[ch] = flags_d[ch].ovf && ctrl_d[ch].ie_ovf;
      adc_d[ch]     = evt_a[ch] && ctrl_q[ch].trig_en;

      // Pin levels on compare match
      pa_oe_d[ch]  = !ctrl_q[ch].a_cap;
      pb_oe_d[ch]  = !ctrl_q[ch].b_cap;
      pa_out_d[ch] = o_pin_a_out[ch];
      pb_out_d[ch] = o_pin_b_out[ch];
      if (ma[ch])
        unique case (ctrl_q[ch].a_out)
          OUT_KEEP:   pa_out_d[ch] = o_pin_a_out[ch];
          OUT_LOW:    pa_out_d[ch] = 1'b0;
          OUT_HIGH:   pa_out_d[ch] = 1'b1;
          OUT_TOGGLE: pa_out_d[ch] = !o_pin_a_out[ch];
        endcase
      if (mb[ch])
        unique case (ctrl_q[ch].b_out)
          OUT_KEEP:   pb_out_d[ch] = o_pin_b_out[ch];
          OUT_LOW:    pb_out_d[ch] = 1'b0;
          OUT_HIGH:   pb_out_d[ch] = 1'b1;
          OUT_TOGGLE: pb_out_d[ch] = !o_pin_b_out[ch];
        endcase

      pend[3*ch]     = irq_a_d[ch];
      pend[3*ch + 1] = irq_b_d[ch];
      pend[3*ch + 2] = irq_ovf_d[ch];
    end

    // Capture buffer transfer beats a buffer write
    if (ctrl_q[0].mode_ext && cap_a[0])
      c_d = a_q[0];
    if (ctrl_q[0].mode_ext && cap_b[0])
      d_d = b_q[0];
    if (ctrl_q[0].alt_src)
      c_d = count_q[0];

    // Lowest index wins: channel 0 first
    top_valid_d = |pend;
    top_src_d   = '0;
    for (int s = NUM_SRC - 1; s >= 0; s--)
      if (pend[s])
        top_src_d = SRC_W'(s);

    // Registers A to D read from next values so a coinciding capture shows
    rdata_d = READ_ZERO;
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      if (i_rd && hit(i_addr, ch, OFS_CTRL))
        rdata_d = DATA_W'(ctrl_q[ch]);
      if (i_rd && hit(i_addr, ch, OFS_COUNT))
        rdata_d = count_q[ch];
      if (i_rd && hit(i_addr, ch, OFS_REG_A))
        rdata_d = a_d[ch];
      if (i_rd && hit(i_addr, ch, OFS_REG_B))
        rdata_d = b_d[ch];
      if (i_rd && hit(i_addr, ch, OFS_STATUS))
        rdata_d = DATA_W'(flags_q[ch]);
    end
    if (i_rd && hit(i_addr, 0, OFS_REG_C))
      rdata_d = c_d;
    if (i_rd && hit(i_addr, 0, OFS_REG_D))
      rdata_d = d_d;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      for (int ch = 0; ch < NUM_CH; ch++)
      begin
        ctrl_q[ch]  <= ctrl_t'(CTRL_RESET);
        count_q[ch] <= COUNT_RESET;
        a_q[ch]     <= REG_RESET;
        b_q[ch]     <= REG_RESET;
        flags_q[ch] <= FLAGS_RESET;
        armed_q[ch] <= FLAGS_RESET;
      end
      c_q             <= REG_RESET;
      d_q             <= REG_RESET;
      div_q           <= DIV_ZERO;
      o_rdata         <= READ_ZERO;
      o_pin_a_out     <= '0;
      o_pin_a_oe      <= '0;
      o_pin_b_out     <= '0;
      o_pin_b_oe      <= '0;
      o_match_irq_a   <= '0;
      o_match_irq_b   <= '0;
      o_overflow_irq  <= '0;
      o_irq_top_valid <= 1'b0;
      o_irq_top_src   <= '0;
      o_adc_start     <= '0;
      pa_s1           <= '0;
      pa_s2           <= '0;
      pa_s3           <= '0;
      pb_s1           <= '0;
      pb_s2           <= '0;
      pb_s3           <= '0;
    end
    else
    begin
      for (int ch = 0; ch < NUM_CH; ch++)
      begin
        ctrl_q[ch]  <= ctrl_d[ch];
        count_q[ch] <= count_d[ch];
        a_q[ch]     <= a_d[ch];
        b_q[ch]     <= b_d[ch];
        flags_q[ch] <= flags_d[ch];
        armed_q[ch] <= armed_d[ch];
      end
      c_q             <= c_d;
      d_q             <= d_d;
      div_q           <= div_d;
      o_rdata         <= rdata_d;
      o_pin_a_out     <= pa_out_d;
      o_pin_a_oe      <= pa_oe_d;
      o_pin_b_out     <= pb_out_d;
      o_pin_b_oe      <= pb_oe_d;
      o_match_irq_a   <= irq_a_d;
      o_match_irq_b   <= irq_b_d;
      o_overflow_irq  <= irq_ovf_d;
      o_irq_top_valid <= top_valid_d;
      o_irq_top_src   <= top_src_d;
      o_adc_start     <= adc_d;
      pa_s1           <= i_pin_a_in;
      pa_s2           <= pa_s1;
      pa_s3           <= pa_s2;
      pb_s1           <= i_pin_b_in;
      pb_s2           <= pb_s1;
      pb_s3           <= pb_s2;
    end
  end

endmodule : timer_event_unit

// >>> sim/timer_event_unit_chk.sv
/*
  Port assertions for the event timer unit.
  Assumes one core clock and a bind from the bench top file.
*/
`timescale 1ns/1ps
module timer_event_unit_chk
  import timer_event_pkg::*;
#(
  parameter int PRESCALE_DIV = 4
)(
  input wire logic                                i_core_clk,
  input wire logic                                i_rst_b,
  input wire logic [timer_event_pkg::ADDR_W-1:0] i_addr,
  input wire logic                                i_wr,
  input wire logic                                i_rd,
  input wire logic [timer_event_pkg::DATA_W-1:0] o_rdata,
  input wire logic [timer_event_pkg::NUM_CH-1:0] o_pin_a_oe,
  input wire logic [timer_event_pkg::NUM_CH-1:0] o_match_irq_a,
  input wire logic [timer_event_pkg::NUM_CH-1:0] o_match_irq_b,
  input wire logic [timer_event_pkg::NUM_CH-1:0] o_overflow_irq,
  input wire logic                                o_irq_top_valid,
  input wire logic [timer_event_pkg::SRC_W-1:0]  o_irq_top_src,
  input wire logic [timer_event_pkg::NUM_CH-1:0] o_adc_start
);
  logic [NUM_SRC-1:0] pend;

  // Source index 3*ch + a, b, ovf
  always_comb
    for (int c = 0; c < NUM_CH; c++)
      pend[3*c +: 3] = {o_overflow_irq[c], o_match_irq_b[c],
                        o_match_irq_a[c]};

  function automatic logic [SRC_W-1:0] top_of(input logic [NUM_SRC-1:0] p);
    top_of = '0;
    for (int s = NUM_SRC - 1; s >= 0; s--)
      if (p[s])
        top_of = SRC_W'(s);
  endfunction : top_of

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_rd_status;
    i_rd && i_addr[3:0] == OFS_STATUS && i_addr[5:4] != 2'h3;
  endsequence
  sequence s_rd_unmapped;
    i_rd && i_addr[5:4] == 2'h3;
  endsequence
  sequence s_after_write;
    $past(i_wr) || $past(i_wr, 2) || !$past(i_rst_b, 2);
  endsequence

  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == READ_ZERO)
    else $error("read data not zero outside a read answer");
  AST_UNMAPPED_ZERO: assert property (s_rd_unmapped |=> o_rdata == READ_ZERO)
    else $error("unmapped read not zero");
  AST_STATUS_HIGH_ZERO: assert property (s_rd_status |=> o_rdata[15:3] == '0)
    else $error("status upper bits not zero");
  AST_TOP_VALID: assert property (o_irq_top_valid == |pend)
    else $error("top valid differs from pending requests");
  AST_TOP_RANK: assert property (o_irq_top_valid |-> o_irq_top_src == top_of(pend))
    else $error("top source not the highest ranked");
  AST_IRQ_FALL: assert property (|($past(pend) & ~pend) |-> s_after_write)
    else $error("request dropped without a write");
  AST_OE_HOLD: assert property ($changed(o_pin_a_oe) |-> s_after_write)
    else $error("pin drive changed without a write");
  AST_RESET_QUIET: assert property ($rose(i_rst_b) |-> !o_irq_top_valid && o_adc_start == '0)
    else $error("outputs active at reset release");
endmodule : timer_event_unit_chk

// >>> sim/converter_model.sv
/*
  Behavioural converter counting timer start pulses.
  Assumes the bench selects whether the timer is the start source.
*/
`timescale 1ns/1ps
module converter_model
  import timer_event_pkg::*;
(
  input  wire logic                                i_core_clk,
  input  wire logic                                i_rst_b,
  input  wire logic [timer_event_pkg::NUM_CH-1:0] i_start,
  input  wire logic                                i_timer_sel,
  output logic      [15:0]                         o_conv_cnt
);
  logic [15:0] conv_cnt_q;
  logic [15:0] conv_cnt_d;

  // Start only counts when the timer is the chosen source
  always_comb
    conv_cnt_d = (i_timer_sel && |i_start) ? conv_cnt_q + 16'h0001
                                           : conv_cnt_q;
  always_ff @(posedge i_core_clk or negedge i_rst_b)
    if (!i_rst_b)
      conv_cnt_q <= 16'h0000;
    else
      conv_cnt_q <= conv_cnt_d;
  assign o_conv_cnt = conv_cnt_q;
endmodule : converter_model

// >>> sim/timer_event_unit_bench.sv
/*
  Self-checking bench for the event timer unit.
  Assumes the package, design, converter model and checker are compiled.
*/
`timescale 1ns/1ps
module timer_event_unit_bench;
  import timer_event_pkg::*;
  localparam int DIV = 2;
  localparam logic [ADDR_W-1:0] RST_A [5] = '{6'h00, 6'h02, 6'h11, 6'h24,
                                               6'h05};
  localparam logic [DATA_W-1:0] RST_V [5] = '{CTRL_RESET, REG_RESET,
                                   COUNT_RESET, READ_ZERO, REG_RESET};
  logic              i_core_clk = 1'b0;
  logic              i_rst_b    = 1'b0;
  logic [ADDR_W-1:0] i_addr     = '0;
  logic [DATA_W-1:0] i_wdata    = '0;
  logic              i_wr       = 1'b0;
  logic              i_rd       = 1'b0;
  logic [NUM_CH-1:0] i_pin_a_in = '0;
  logic [NUM_CH-1:0] i_pin_b_in = '0;
  logic [DATA_W-1:0] o_rdata;
  logic [NUM_CH-1:0] o_pin_a_out, o_pin_a_oe, o_pin_b_out, o_pin_b_oe;
  logic [NUM_CH-1:0] o_match_irq_a, o_match_irq_b, o_overflow_irq;
  logic [NUM_CH-1:0] o_adc_start;
  logic              o_irq_top_valid;
  logic [SRC_W-1:0]  o_irq_top_src;
  logic              timer_sel = 1'b0;
  logic [15:0]       conv_cnt, conv, ctrl, w;
  logic [DATA_W-1:0] rd_q;
  int                n_mismatch  = 0;
  int                comparisons = 0;
  int                n, t;

  always #50 i_core_clk = ~i_core_clk;

  timer_event_unit #(.PRESCALE_DIV(DIV)) u_timer_event_unit (.*);
  converter_model u_converter_model (.i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b), .i_start(o_adc_start), .i_timer_sel(timer_sel),
    .o_conv_cnt(conv_cnt));

  function automatic logic [ADDR_W-1:0] ad(input int c,
                                           input logic [OFS_W-1:0] o);
    ad = {2'(c), o};
  endfunction : ad

  task automatic chk(input string what, input logic [DATA_W-1:0] exp,
                     input logic [DATA_W-1:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic settle(input int k);
    repeat (k) @(posedge i_core_clk);
    #1;
  endtask : settle

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_core_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge i_core_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 rd_q = o_rdata;
  endtask : rd

  task automatic wait_adc(input int c, output int cyc);
    cyc = 0;
    do
    begin
      settle(1);
      cyc++;
    end
    while (o_adc_start[c] !== 1'b1 && cyc < 64);
    if (cyc >= 64)
    begin
      chk("converter start", 16'h0001, 16'h0000);
      test_done();
    end
  endtask : wait_adc

  task automatic test_done();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons,
             n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  initial
  begin
    void'($urandom(32'hb41ebf38));
    repeat (2) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      rd(RST_A[k]);
      chk("reset value", RST_V[k], rd_q);
    end
    wr(6'h30, 16'h5a5a);
    rd(6'h30);
    chk("unmapped read", READ_ZERO, rd_q);
    $display("test reset done");
    // Match period, pin level and converter start per channel
    for (int c = 0; c < NUM_CH; c++)
    begin
      n = 2 + $urandom % 6;
      timer_sel = (c != 2);
      conv = conv_cnt;
      ctrl = 16'h1243 | (c == 1 ? 16'h8000 : 16'h0000);
      wr(ad(c, OFS_REG_A), DATA_W'(n));
      wr(ad(c, OFS_CTRL), ctrl);
      wait_adc(c, t);
      wait_adc(c, t);
      chk("period", DATA_W'((n + 1) * (c == 1 ? DIV : 1)), DATA_W'(t));
      wr(ad(c, OFS_CTRL), ctrl & 16'hfffe);
      settle(1);
      chk("pin", 16'h0003, DATA_W'({o_pin_a_oe[c], o_pin_a_out[c]}));
      chk("conversion", DATA_W'(c != 2), DATA_W'(conv_cnt != conv));
    end
    $display("test period done");
    for (int c = 0; c < NUM_CH; c++)
    begin
      settle(2);
      chk("top source", DATA_W'(3 * c), DATA_W'(o_irq_top_src));
      wr(ad(c, OFS_STATUS), 16'h0000);
      rd(ad(c, OFS_STATUS));
      chk("flag kept", 16'h0001, rd_q);
      wr(ad(c, OFS_STATUS), 16'h0000);
      settle(2);
      chk("request", 16'h0000, DATA_W'(o_match_irq_a[c]));
    end
    chk("any request", 16'h0000, DATA_W'(o_irq_top_valid));
    $display("test clear done");
    w = 16'h0100 + 16'($urandom % 16'he000);
    wr(ad(1, OFS_CTRL), 16'h0801);
    wr(ad(1, OFS_COUNT), 16'hfffe);
    wr(ad(1, OFS_COUNT), w);
    rd(ad(1, OFS_COUNT));
    chk("count", w + 16'h0001, rd_q);
    rd(ad(1, OFS_STATUS));
    chk("overflow", 16'h0000, rd_q & 16'h0004);
    wr(ad(1, OFS_COUNT), 16'hfffe);
    settle(3);
    chk("overflow request", 16'h0001, DATA_W'(o_overflow_irq[1]));
    rd(ad(1, OFS_STATUS));
    wr(ad(1, OFS_STATUS), 16'h0000);
    wr(ad(1, OFS_REG_A), 16'hffff);
    wr(ad(1, OFS_CTRL), 16'h0803);
    wr(ad(1, OFS_COUNT), 16'hfff0);
    settle(20);
    wr(ad(1, OFS_CTRL), 16'h0802);
    rd(ad(1, OFS_STATUS));
    chk("clear on overflow", 16'h0001, rd_q & 16'h0005);
    // Cascade: both halves set up with no clearing, channel 1 in cascade mode, channel 2 counting
    wr(ad(1, OFS_CTRL), 16'h2001);
    wr(ad(1, OFS_COUNT), 16'h0000);
    wr(ad(2, OFS_COUNT), 16'hfffd);
    wr(ad(2, OFS_CTRL), 16'h0001);
    settle(6);
    wr(ad(2, OFS_CTRL), 16'h0000);
    wr(ad(1, OFS_CTRL), 16'h2000);
    rd(ad(1, OFS_COUNT));
    chk("upper count", 16'h0001, rd_q);
    $display("test contention done");
    test_done();
  end
endmodule : timer_event_unit_bench

bind timer_event_unit timer_event_unit_chk #(.PRESCALE_DIV(PRESCALE_DIV))
  u_chk (.*);
